// ### bma_buffer_memory_arbiter.sv
// Packet buffer RAM arbiter and memory bus state tracker.
// Operation
// [RQ1] Never start a host bus cycle; only answer as a slave.
// [RQ2] Memory bus is master, slave to the host CPU, or idle.
// [RQ3] After hardware reset: slave in reset state, receiver and sender off.
// [RQ4] Stop, register reset, hardware reset or FIFO/ring error reenter reset.
// [RQ5] Software sets up, then start moves reset to idle until DMA needed.
// [RQ6] A FIFO request makes the device drive the memory bus.
// [RQ7] In port mode the remote DMA also requests the memory bus.
// [RQ8] In shared mode the host CPU reaches the memory bus directly.
// [RQ9] Local bursts move exactly the programmed byte count, then release.
// [RQ10] With bytes left over, next burst waits for the FIFO threshold.
// [RQ11] Remote transfers pause while local packet DMA runs.
// [RQ12] After the local burst, remote requests again and resumes.
// [RQ13] FIFO service during a remote word is appended to it.
// [RQ14] A gap follows each local burst before any remote grant.
// [RQ15] Port mode moves host data only through the data port.
// [RQ16] Remote DMA arbitrates per word and releases after each.
// [RQ17] One grant at most; local wins a same cycle contest.
// [RQ18] Decisions are clocked; no grant while in the reset state.
`timescale 1ns/1ps
module bma_buffer_memory_arbiter #(
   parameter int GAP_CYCLES = bma_pkg::GAP_CYCLES
) (
   // Clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          reset,
   // Commands and shutdown events
   input  wire logic                          cmdStart,
   input  wire logic                          cmdStop,
   input  wire logic                          regResetPort,
   input  wire logic                          ctrlResetBit,
   input  wire logic                          fifoUnderflow,
   input  wire logic                          fifoOverflow,
   input  wire logic                          ringOverflow,
   // Configuration
   input  wire logic                          sharedMode,
   input  wire logic [bma_pkg::BURST_SEL_W-1:0] burstSel,
   // Requesters
   input  wire logic                          fifoReq,
   input  wire logic                          fifoResidual,
   input  wire logic                          fifoThreshold,
   input  wire logic                          remoteReq,
   input  wire logic                          cpuReq,
   // Memory bus
   input  wire logic                          memDone,
   output logic                               grantLocal,
   output logic                               grantRemote,
   output logic                               grantCpu,
   // Status
   output logic [1:0]                         busState,
   output logic                               rxEnable,
   output logic                               txEnable,
   output logic                               remoteHeld,
   output logic                               hostBusRequest
);
   bma_pkg::bma_state_e state_reg;
   bma_pkg::bma_state_e state_next;
   bma_pkg::bma_owner_e owner_reg;
   bma_pkg::bma_owner_e owner_next;
   logic                armed_reg;
   logic                armed_next;
   logic                held_reg;
   logic                held_next;
   logic                abortAny;
   logic                xfer;
   logic                localWant;
   logic                remoteWant;
   logic                cpuWant;
   logic                grantLocal_reg;
   logic                grantLocal_next;
   logic                grantRemote_reg;
   logic                grantRemote_next;
   logic                grantCpu_reg;
   logic                grantCpu_next;
   logic                enable_reg;
   logic                enable_next;
   logic                hostReq_reg;
   logic                hostReq_next;

   bma_arb_if #(.CW(bma_pkg::BURST_W), .GW(bma_pkg::GAP_W)) arbIf ();

   bma_burst_counter #(.CW(bma_pkg::BURST_W)) uBurst (
      .sys_clk (sys_clk),
      .reset   (reset),
      .bus     (arbIf.ctr)
   );

   bma_gap_timer #(.GW(bma_pkg::GAP_W), .GAPS(GAP_CYCLES)) uGap (
      .sys_clk (sys_clk),
      .reset   (reset),
      .bus     (arbIf.gap)
   );

   function automatic bma_pkg::bma_state_e stateFor(
      input bma_pkg::bma_owner_e own);
      case (own)
         bma_pkg::OWN_NONE:   stateFor = bma_pkg::ST_IDLE;
         bma_pkg::OWN_CPU:    stateFor = bma_pkg::ST_SLAVE;
         default:             stateFor = bma_pkg::ST_MASTER;
      endcase
   endfunction : stateFor

   // The register reset source depends on the host access mode.
   assign abortAny = cmdStop | fifoUnderflow | fifoOverflow |
                     ringOverflow | (!sharedMode & regResetPort) |
                     (sharedMode & ctrlResetBit); // see RQ4
   assign xfer       = memDone && (owner_reg != bma_pkg::OWN_NONE);
   assign localWant  = fifoReq && (armed_reg || fifoThreshold); // see RQ10
   // Remote DMA only exists in port mode, and it waits out the gap.
   assign remoteWant = !sharedMode && remoteReq &&
                       !arbIf.gapBusy; // see RQ7 see RQ14
   assign cpuWant    = sharedMode && cpuReq; // see RQ8

   assign arbIf.burstLen  = bma_pkg::burstBytes(burstSel);
   assign arbIf.burstLoad = (owner_next == bma_pkg::OWN_LOCAL) &&
                            (owner_reg != bma_pkg::OWN_LOCAL);
   assign arbIf.burstTick = xfer && (owner_reg == bma_pkg::OWN_LOCAL);
   // Aborted bursts start the gap too, so a restart cannot skip it.
   assign arbIf.gapStart  = (owner_reg == bma_pkg::OWN_LOCAL) &&
                            (owner_next != bma_pkg::OWN_LOCAL); // see RQ14

   always_comb begin
      state_next = state_reg;
      owner_next = owner_reg;
      armed_next = armed_reg | fifoThreshold;
      if (abortAny) begin
         state_next = bma_pkg::ST_RESET; // see RQ4
         owner_next = bma_pkg::OWN_NONE;
         armed_next = 1'b1;
      end else begin
         case (state_reg)
            bma_pkg::ST_RESET: begin
               if (cmdStart) begin
                  state_next = bma_pkg::ST_IDLE; // see RQ5
               end
            end
            default: begin
               case (owner_reg)
                  bma_pkg::OWN_NONE: begin
                     // Fixed priority: local, then remote, then CPU.
                     if (localWant) begin
                        owner_next = bma_pkg::OWN_LOCAL; // see RQ6 see RQ17
                     end else if (remoteWant) begin
                        owner_next = bma_pkg::OWN_REMOTE; // see RQ12
                     end else if (cpuWant) begin
                        owner_next = bma_pkg::OWN_CPU;
                     end
                  end
                  bma_pkg::OWN_LOCAL: begin
                     if (arbIf.burstDone) begin
                        owner_next = bma_pkg::OWN_NONE; // see RQ9
                        if (fifoResidual && !fifoThreshold) begin
                           armed_next = 1'b0; // see RQ10
                        end
                     end
                  end
                  bma_pkg::OWN_REMOTE: begin
                     if (xfer) begin
                        // A waiting FIFO takes the bus without release.
                        owner_next = localWant ? bma_pkg::OWN_LOCAL
                                               : bma_pkg::OWN_NONE;
                     end // see RQ13 see RQ16
                  end
                  default: begin
                     if (xfer) begin
                        owner_next = bma_pkg::OWN_NONE;
                     end
                  end
               endcase
               state_next = stateFor(owner_next); // see RQ2
            end
         endcase
      end
      held_next = !sharedMode && remoteReq &&
                  (owner_next == bma_pkg::OWN_LOCAL); // see RQ11
      // Grants load from the next owner, so they never lag the owner.
      grantLocal_next  = (owner_next == bma_pkg::OWN_LOCAL);
      grantRemote_next = (owner_next == bma_pkg::OWN_REMOTE); // see RQ15
      grantCpu_next    = (owner_next == bma_pkg::OWN_CPU);
      enable_next      = (state_next != bma_pkg::ST_RESET); // see RQ3
      hostReq_next     = 1'b0; // see RQ1
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= bma_pkg::ST_RESET; // see RQ3
         owner_reg <= bma_pkg::OWN_NONE; // see RQ18
         armed_reg <= 1'b1;
         held_reg  <= 1'b0;
         grantLocal_reg  <= 1'b0;
         grantRemote_reg <= 1'b0;
         grantCpu_reg    <= 1'b0;
         enable_reg      <= 1'b0;
         hostReq_reg     <= 1'b0;
      end else begin
         state_reg <= state_next;
         owner_reg <= owner_next;
         armed_reg <= armed_next;
         held_reg  <= held_next;
         grantLocal_reg  <= grantLocal_next;
         grantRemote_reg <= grantRemote_next;
         grantCpu_reg    <= grantCpu_next;
         enable_reg      <= enable_next;
         hostReq_reg     <= hostReq_next;
      end
   end

   // Each output comes straight from a flip-flop (rxEnable and txEnable share enable_reg), so no decode glitch escapes.
   assign grantLocal     = grantLocal_reg;
   // Remote grant is the only path from RAM to the host data port.
   assign grantRemote    = grantRemote_reg; // see RQ15
   assign grantCpu       = grantCpu_reg;
   assign busState       = state_reg;
   assign rxEnable       = enable_reg; // see RQ3
   assign txEnable       = enable_reg;
   assign remoteHeld     = held_reg;
   assign hostBusRequest = hostReq_reg; // see RQ1

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence localEnd;
      grantLocal && arbIf.burstDone && !abortAny;
   endsequence

   sequence remoteQuiet;
      !grantRemote [*3];
   endsequence

   one_grant_a: assert property ( // see RQ17
      $onehot0({grantLocal, grantRemote, grantCpu}))
      else $error("More than one memory bus grant.");

   reset_nogrant_a: assert property ( // see RQ18
      (state_reg == bma_pkg::ST_RESET) |->
      !(grantLocal || grantRemote || grantCpu) && !rxEnable)
      else $error("Grant or receiver active in reset state.");

   abort_reset_a: assert property ( // see RQ4
      abortAny |=> (state_reg == bma_pkg::ST_RESET) && !txEnable)
      else $error("Shutdown event did not enter reset state.");

   start_idle_a: assert property ( // see RQ5
      (state_reg == bma_pkg::ST_RESET) && cmdStart && !abortAny |=>
      (busState == bma_pkg::ST_IDLE) ##1 1'b1)
      else $error("Start did not reach idle.");

   local_first_a: assert property ( // see RQ11
      (state_reg != bma_pkg::ST_RESET) && !abortAny &&
      (owner_reg == bma_pkg::OWN_NONE) && localWant && remoteWant
      |=> grantLocal && remoteHeld)
      else $error("Remote won against local request.");

   burst_end_a: assert property ( // see RQ9
      localEnd |=> !grantLocal ##0 (busState != bma_pkg::ST_MASTER ||
      grantRemote == 1'b0))
      else $error("Local grant held past burst end.");

   gap_hold_a: assert property ( // see RQ14
      $fell(grantLocal) |-> remoteQuiet)
      else $error("Remote granted inside the ownership gap.");

   remote_word_a: assert property ( // see RQ16
      grantRemote && memDone |=> !grantRemote)
      else $error("Remote grant kept after one word.");

   append_a: assert property ( // see RQ13
      grantRemote && memDone && localWant && !abortAny |=> grantLocal)
      else $error("Local burst not appended to remote word.");

   armed_wait_a: assert property ( // see RQ10
      !armed_reg && !fifoThreshold && !grantLocal |=> !grantLocal)
      else $error("Burst began below the FIFO threshold.");

   slave_state_a: assert property ( // see RQ2
      grantCpu |-> (busState == bma_pkg::ST_SLAVE) &&
      ($past(grantCpu) || $past(sharedMode)))
      else $error("CPU grant outside slave state.");

   sequence idleLocal;
      (busState == bma_pkg::ST_IDLE) && localWant && !abortAny;
   endsequence

   idle_exit_a: assert property ( // see RQ6
      idleLocal |=> grantLocal && (busState == bma_pkg::ST_MASTER))
      else $error("FIFO request did not take the memory bus.");

   start_wait_a: assert property ( // see RQ5
      (state_reg == bma_pkg::ST_RESET) && !cmdStart |=>
      (state_reg == bma_pkg::ST_RESET))
      else $error("Reset state left without a start command.");

   held_free_a: assert property ( // see RQ11
      grantRemote |-> !remoteHeld)
      else $error("Remote held while it owns the bus.");

   port_only_a: assert property ( // see RQ7
      sharedMode && !grantRemote |=> !grantRemote)
      else $error("Remote granted in shared memory mode.");

   cpu_shared_a: assert property ( // see RQ8
      !sharedMode && !grantCpu |=> !grantCpu)
      else $error("CPU granted in port mode.");

   no_host_cycle_a: assert property ( // see RQ1
      !hostBusRequest)
      else $error("Host bus cycle requested.");
endmodule : bma_buffer_memory_arbiter

// ### bma_pkg.sv
// Shared constants, types and decoders for the buffer memory arbiter.
package bma_pkg;

   typedef enum logic [1:0] {
      ST_RESET  = 2'b00,
      ST_IDLE   = 2'b01,
      ST_MASTER = 2'b10,
      ST_SLAVE  = 2'b11
   } bma_state_e;

   typedef enum logic [1:0] {
      OWN_NONE   = 2'b00,
      OWN_LOCAL  = 2'b01,
      OWN_REMOTE = 2'b10,
      OWN_CPU    = 2'b11
   } bma_owner_e;

   // Burst counter and burst length field layout.
   localparam int BURST_W     = 4;
   localparam int BURST_SEL_W = 2;
   localparam logic [BURST_W-1:0] BURST_BYTES_0 = 4'h2;
   localparam logic [BURST_W-1:0] BURST_BYTES_1 = 4'h4;
   localparam logic [BURST_W-1:0] BURST_BYTES_2 = 4'h8;
   localparam logic [BURST_W-1:0] BURST_BYTES_3 = 4'hC;
   localparam logic [BURST_W-1:0] BURST_LAST    = 4'h1;

   // Ownership gap between a local burst and the next remote word.
   localparam int CLK_PERIOD_NS = 10;
   localparam int GAP_NS        = 20;
   localparam int GAP_CYCLES    = (GAP_NS + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
   localparam int GAP_W         = 2;

   function automatic logic [BURST_W-1:0] burstBytes(
      input logic [BURST_SEL_W-1:0] sel);
      case (sel)
         2'h0:    burstBytes = BURST_BYTES_0;
         2'h1:    burstBytes = BURST_BYTES_1;
         2'h2:    burstBytes = BURST_BYTES_2;
         default: burstBytes = BURST_BYTES_3;
      endcase
   endfunction : burstBytes

endpackage : bma_pkg

// ### bma_arb_if.sv
// Links the arbiter core with its burst counter and gap timer.
`timescale 1ns/1ps
interface bma_arb_if #(
   parameter int CW = 4,
   parameter int GW = 2
) ();
   logic          burstLoad;
   logic          burstTick;
   logic [CW-1:0] burstLen;
   logic          burstDone;
   logic          gapStart;
   logic          gapBusy;

   modport arb (output burstLoad, output burstTick, output burstLen,
                output gapStart, input burstDone, input gapBusy);
   modport ctr (input burstLoad, input burstTick, input burstLen,
                output burstDone);
   modport gap (input gapStart, output gapBusy);
endinterface : bma_arb_if

// ### bma_burst_counter.sv
// Counts the bytes of one local DMA burst down to its last byte.
`timescale 1ns/1ps
module bma_burst_counter #(
   parameter int CW = bma_pkg::BURST_W
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Arbiter link
   bma_arb_if.ctr   bus
);
   logic [CW-1:0] left_reg;
   logic [CW-1:0] left_next;

   if (CW < bma_pkg::BURST_W) begin : g_chk
      $error("Burst counter too narrow for the longest burst.");
   end

   assign bus.burstDone = bus.burstTick &&
                          (left_reg == CW'(bma_pkg::BURST_LAST));

   always_comb begin
      left_next = left_reg;
      if (bus.burstLoad) begin
         left_next = bus.burstLen;
      end else if (bus.burstTick && left_reg != '0) begin
         left_next = left_reg - CW'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         left_reg <= '0;
      end else begin
         left_reg <= left_next;
      end
   end
endmodule : bma_burst_counter

// ### bma_gap_timer.sv
// Holds off remote grants for a fixed gap after a local burst.
`timescale 1ns/1ps
module bma_gap_timer #(
   parameter int GW   = bma_pkg::GAP_W,
   parameter int GAPS = bma_pkg::GAP_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Arbiter link
   bma_arb_if.gap   bus
);
   logic [GW-1:0] cnt_reg;
   logic [GW-1:0] cnt_next;

   if (GAPS < 1 || GAPS >= (1 << GW)) begin : g_chk
      $error("Gap length does not fit the gap counter.");
   end

   assign bus.gapBusy = (cnt_reg != '0);

   always_comb begin
      cnt_next = cnt_reg;
      if (bus.gapStart) begin
         cnt_next = GW'(GAPS);
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - GW'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule : bma_gap_timer

// ### bma_ram_model.sv
// Packet buffer RAM model that answers each granted cycle after a wait.
`timescale 1ns/1ps
module bma_ram_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Memory bus
   input  wire logic       anyGrant,
   input  wire logic [1:0] waitCycles,
   output logic            memDone
);
   logic [1:0] waitReg;
   logic [1:0] waitNext;

   // A slow answer stretches every byte cycle, so burst length must be
   // counted in completions and never in clock cycles.
   always_comb begin
      memDone  = anyGrant && (waitReg == waitCycles);
      waitNext = (!anyGrant || memDone) ? 2'h0 : waitReg + 2'h1;
   end

   always_ff @(posedge sys_clk) begin
      waitReg <= reset ? 2'h0 : waitNext;
   end
endmodule : bma_ram_model

// ### bma_buffer_memory_arbiter_tb.sv
// Self-checking bench for the buffer memory arbiter.
`timescale 1ns/1ps
module bma_buffer_memory_arbiter_tb;
   localparam int GAP = 2;
   logic       sys_clk = 1'b0;
   logic       reset = 1'b1;
   logic       cmdStart = 1'b0;
   logic [5:0] abortVec = 6'h00;
   logic       sharedMode = 1'b0;
   logic [1:0] burstSel = 2'h0;
   logic       fifoReq = 1'b0;
   logic       fifoResidual = 1'b0;
   logic       fifoThreshold = 1'b1;
   logic       remoteReq = 1'b0;
   logic       cpuReq = 1'b0;
   logic [1:0] ramWait = 2'h0;
   logic       memDone, grantLocal, grantRemote, grantCpu;
   logic [1:0] busState;
   logic       rxEnable, txEnable, remoteHeld, hostBusRequest;
   logic [3:0] bytesTab [4] = '{bma_pkg::BURST_BYTES_0,
      bma_pkg::BURST_BYTES_1, bma_pkg::BURST_BYTES_2, bma_pkg::BURST_BYTES_3};
   int         errors = 0;
   int         cmp_count = 0;
   int         cycles = 0;
   int         k;

   bma_buffer_memory_arbiter #(.GAP_CYCLES(GAP)) u_dut (
      .sys_clk(sys_clk), .reset(reset), .cmdStart(cmdStart),
      .cmdStop(abortVec[0]), .regResetPort(abortVec[1]),
      .ctrlResetBit(abortVec[2]), .fifoUnderflow(abortVec[3]),
      .fifoOverflow(abortVec[4]), .ringOverflow(abortVec[5]),
      .sharedMode(sharedMode), .burstSel(burstSel), .fifoReq(fifoReq),
      .fifoResidual(fifoResidual), .fifoThreshold(fifoThreshold),
      .remoteReq(remoteReq), .cpuReq(cpuReq), .memDone(memDone),
      .grantLocal(grantLocal), .grantRemote(grantRemote),
      .grantCpu(grantCpu), .busState(busState), .rxEnable(rxEnable),
      .txEnable(txEnable), .remoteHeld(remoteHeld),
      .hostBusRequest(hostBusRequest));

   bma_ram_model u_ram (
      .sys_clk(sys_clk), .reset(reset),
      .anyGrant(grantLocal | grantRemote | grantCpu),
      .waitCycles(ramWait), .memDone(memDone));

   always #5 sys_clk = ~sys_clk;

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic chk(input string what, input logic [3:0] exp,
                      input logic [3:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic grantOf(input int w);
      return (w == 0) ? grantLocal : (w == 1) ? grantRemote : grantCpu;
   endfunction : grantOf

   // Waits a bounded time for one grant to reach a level.
   task automatic waitFor(input int w, input logic v, output int n);
      n = 0;
      while (grantOf(w) !== v && n < 50) begin
         tick(1);
         n++;
      end
      chk("grant level", {3'h0, v}, {3'h0, grantOf(w)});
   endtask : waitFor

   task automatic startDev();
      cmdStart = 1'b1;
      tick(1);
      cmdStart = 1'b0;
      chk("busState", 4'h1, {2'h0, busState});
      chk("rx tx", 4'h3, {2'h0, rxEnable, txEnable});
   endtask : startDev

   task automatic burst(input logic [1:0] sel, input logic [3:0] exp);
      logic [3:0] cnt;
      int         n;
      cnt = 4'h0;
      burstSel = sel;
      fifoReq = 1'b1;
      waitFor(0, 1'b1, n);
      chk("busState", 4'h2, {2'h0, busState});
      fifoReq = 1'b0;
      n = 0;
      while (grantLocal === 1'b1 && n < 60) begin
         if (memDone === 1'b1)
            cnt++;
         tick(1);
         n++;
      end
      chk("burst bytes", exp, cnt);
   endtask : burst

   // Ceiling well above the roughly 120 cycles the tests need.
   always @(negedge sys_clk) begin
      cycles++;
      if (cycles > 3000) begin
         errors++;
         end_sim();
      end
   end

   // Ownership checks, sampled mid-cycle where the outputs are settled.
   always @(negedge sys_clk) begin
      if (!reset) begin
         chk("one grant", 4'h1,
             {3'h0, $onehot0({grantLocal, grantRemote, grantCpu})});
         chk("hostBusRequest", 4'h0, {3'h0, hostBusRequest});
         if (busState === 2'h0)
            chk("reset grants", 4'h0,
                {1'h0, grantLocal, grantRemote, grantCpu});
      end
   end

   initial begin
      tick(4);
      chk("busState", 4'h0, {2'h0, busState});
      chk("rx tx", 4'h0, {2'h0, rxEnable, txEnable});
      reset = 1'b0;
      startDev();
      $display("test reset_start done");
      for (int i = 0; i < 4; i++) begin
         ramWait = 2'(i % 3);
         burst(2'(i), bytesTab[i]);
      end
      $display("test burst_lengths done");
      ramWait = 2'h0;
      fifoResidual = 1'b1;
      fifoThreshold = 1'b0;
      burst(2'h0, bytesTab[0]);
      fifoResidual = 1'b0;
      fifoReq = 1'b1;
      tick(8);
      chk("held burst", 4'h0, {3'h0, grantLocal});
      fifoThreshold = 1'b1;
      waitFor(0, 1'b1, k);
      fifoReq = 1'b0;
      waitFor(0, 1'b0, k);
      // Threshold seen high at the burst end keeps the next burst armed.
      fifoResidual = 1'b1;
      burst(2'h0, bytesTab[0]);
      fifoResidual = 1'b0;
      fifoThreshold = 1'b0;
      fifoReq = 1'b1;
      waitFor(0, 1'b1, k);
      fifoReq = 1'b0;
      fifoThreshold = 1'b1;
      waitFor(0, 1'b0, k);
      $display("test threshold done");
      fifoReq = 1'b1;
      remoteReq = 1'b1;
      tick(2);
      chk("local wins", 4'h2, {2'h0, grantLocal, grantRemote});
      chk("remoteHeld", 4'h1, {3'h0, remoteHeld});
      fifoReq = 1'b0;
      waitFor(0, 1'b0, k);
      waitFor(1, 1'b1, k);
      chk("remoteHeld", 4'h0, {3'h0, remoteHeld});
      chk("gap", 4'h1, {3'h0, k >= GAP + 1});
      tick(1);
      chk("word release", 4'h0, {3'h0, grantRemote});
      waitFor(1, 1'b1, k);
      remoteReq = 1'b0;
      tick(2);
      $display("test interleave done");
      ramWait = 2'h2;
      remoteReq = 1'b1;
      waitFor(1, 1'b1, k);
      fifoReq = 1'b1;
      waitFor(1, 1'b0, k);
      remoteReq = 1'b0;
      chk("append", 4'h1, {3'h0, grantLocal});
      fifoReq = 1'b0;
      waitFor(0, 1'b0, k);
      $display("test append done");
      ramWait = 2'h0;
      sharedMode = 1'b1;
      remoteReq = 1'b1;
      cpuReq = 1'b1;
      waitFor(2, 1'b1, k);
      chk("busState", 4'h3, {2'h0, busState});
      cpuReq = 1'b0;
      tick(4);
      chk("no remote", 4'h0, {3'h0, grantRemote});
      remoteReq = 1'b0;
      for (int i = 1; i < 3; i++) begin
         sharedMode = (i == 1);
         abortVec[i] = 1'b1;
         tick(1);
         abortVec[i] = 1'b0;
         chk("ignored reset", 4'h1, {2'h0, busState});
      end
      for (int i = 0; i < 7; i++) begin
         sharedMode = (i == 2);
         startDev();
         if (i == 6)
            reset = 1'b1;
         else
            abortVec[i] = 1'b1;
         tick(1);
         abortVec = 6'h00;
         reset = 1'b0;
         chk("busState", 4'h0, {2'h0, busState});
         chk("rx tx", 4'h0, {2'h0, rxEnable, txEnable});
      end
      $display("test shared_and_aborts done");
      end_sim();
   end
endmodule : bma_buffer_memory_arbiter_tb
